// ===== bus_controller_config_image.v
// Configuration image of a serial-bus controller as read and partly written by its host.
// Assumes the host port and the controller logic share clk_sys; the switch is a raw pin.
//
// Notes on behaviour
// - Byte zero gives fixed read-only variant code.
// - Bytes two, three: device count, own number.
// - Own device number one to thirty-one, read-only.
// - Read-only bitmap marks assigned eight-reference groups.
// - Sixteen input bytes, then sixteen output bytes.
// - Register-memory blocks excluded; no owner information.
// - Per-device flag set stops outputs to device.
// - Device zero is lsb of first byte.
// - Power-up flags all clear or all set.
// - Global data address defaults to all ones.
// - Global data length never exceeds 128 bytes.
// - Global data length clears to zero.
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
`include "cfg_image_consts.vh"

module bus_controller_config_image #(
	// Arbitrary neutral values, not tied to any real product.
	parameter [7:0] VARIANT_CODE = 8'h5a,
	parameter [7:0] REVISION_CODE = 8'h10,
	// Later variant: inhibit flags and global data fields exist.
	parameter EXTENDED = 1
) (
	input wire clk_sys,
	input wire srst,
	input wire [`ADDR_W-1:0] addr,
	input wire [7:0] wdata,
	input wire wr,
	input wire rd,
	output reg [7:0] rdata,
	input wire [7:0] active_device_count,
	input wire [`OWN_DEV_W-1:0] own_device_number,
	input wire [`LINK_RATE_W-1:0] link_rate_code,
	input wire alloc_clear,
	input wire alloc_update,
	input wire alloc_is_output,
	input wire alloc_is_register,
	input wire [6:0] alloc_group,
	input wire alloc_value,
	input wire inhibit_switch,
	input wire [`DEVICES-1:0] device_present,
	output reg [`DEVICES-1:0] output_inhibit,
	output wire [`DEVICES-1:0] output_send_allowed,
	output reg [15:0] global_data_start,
	output reg [15:0] global_data_length,
	output wire global_data_active
);

	reg switch_meta;
	reg switch_sync;
	reg power_up_load;
	reg [7:0] device_count;
	reg [`OWN_DEV_W-1:0] own_number;
	reg [`LINK_RATE_W-1:0] link_rate;
	reg [7:0] next_rdata;
	reg [15:0] next_length;
	wire [`MAP_GROUPS-1:0] input_reference_map;
	wire [`MAP_GROUPS-1:0] output_reference_map;
	wire alloc_take;
	wire [7:0] map_index;
	wire [7:0] flag_index;
	wire ext_on;

	assign ext_on = (EXTENDED != 0);

	// Replaces one byte of a 16-bit field; hi selects the upper byte.
	function [15:0] merge_byte;
		input [15:0] old;
		input [7:0] data;
		input hi;
		begin
			if (hi) begin
				merge_byte = {data, old[7:0]};
			end else begin
				merge_byte = {old[15:8], data};
			end
		end
	endfunction

	// True when a address falls in a field of the given base and byte count.
	function in_field;
		input [`ADDR_W-1:0] a;
		input [`ADDR_W-1:0] base;
		input [`ADDR_W-1:0] count;
		begin
			in_field = (a >= base) && (a < base + count);
		end
	endfunction

	// The switch is a pin, so it is synchronised before anything samples it.
	always @(posedge clk_sys) begin
		switch_meta <= inhibit_switch;
		switch_sync <= switch_meta;
	end

	// Status bytes are captured from controller logic so readback is stable.
	always @(posedge clk_sys) begin
		if (srst) begin
			device_count <= 8'h00;
			own_number <= `OWN_DEV_MIN;
			link_rate <= {`LINK_RATE_W{1'b0}};
		end else begin
			device_count <= active_device_count;
			// Zero is not a valid own number; the last legal value is held instead.
			if (own_device_number != {`OWN_DEV_W{1'b0}}) begin
				own_number <= own_device_number;
			end
			link_rate <= link_rate_code;
		end
	end

	// Register-memory allocations never reach the bitmap.
	assign alloc_take = alloc_update && !alloc_is_register;

	ref_group_map #(
		.GROUPS(`MAP_GROUPS),
		.USED_GROUPS(`MAP_USED_GROUPS),
		.GROUP_W(7)
	) u_input_map (
		.clk_sys(clk_sys),
		.srst(srst),
		.clear_all(alloc_clear),
		.update_en(alloc_take && !alloc_is_output),
		.group(alloc_group),
		.value(alloc_value),
		.map(input_reference_map)
	);

	ref_group_map #(
		.GROUPS(`MAP_GROUPS),
		.USED_GROUPS(`MAP_USED_GROUPS),
		.GROUP_W(7)
	) u_output_map (
		.clk_sys(clk_sys),
		.srst(srst),
		.clear_all(alloc_clear),
		.update_en(alloc_take && alloc_is_output),
		.group(alloc_group),
		.value(alloc_value),
		.map(output_reference_map)
	);

	// Inhibit flags: reset clears them, then the first cycle after release
	// loads all of them from the switch, since reset may only load constants.
	always @(posedge clk_sys) begin
		if (srst) begin
			output_inhibit <= {`DEVICES{1'b0}};
			power_up_load <= 1'b1;
		end else begin
			power_up_load <= 1'b0;
			if (power_up_load) begin
				output_inhibit <= {`DEVICES{switch_sync}};
			end else if (ext_on && wr && in_field(addr, `OFS_INHIBIT, `INHIBIT_BYTES)) begin
				case (flag_index[1:0])
					2'h0: output_inhibit[7:0] <= wdata;
					2'h1: output_inhibit[15:8] <= wdata;
					2'h2: output_inhibit[23:16] <= wdata;
					2'h3: output_inhibit[31:24] <= wdata;
					default: output_inhibit <= output_inhibit;
				endcase
			end
		end
	end

	// A device gets outputs only when present and its flag is clear.
	assign output_send_allowed = ext_on ? (device_present & ~output_inhibit)
		: device_present;

	assign flag_index = addr - `OFS_INHIBIT;

	// Length is saturated so the stored value never passes the limit.
	always @* begin
		next_length = merge_byte(global_data_length, wdata, addr == `OFS_GD_LEN + 8'h01);
		if (next_length > `GD_LEN_MAX) begin
			next_length = `GD_LEN_MAX;
		end
	end

	always @(posedge clk_sys) begin
		if (srst) begin
			global_data_start <= `GD_ADDR_RESET;
			global_data_length <= `GD_LEN_RESET;
		end else if (ext_on && wr) begin
			if (in_field(addr, `OFS_GD_ADDR, 8'h02)) begin
				global_data_start <= merge_byte(global_data_start, wdata,
					addr == `OFS_GD_ADDR + 8'h01);
			end
			if (in_field(addr, `OFS_GD_LEN, 8'h02)) begin
				global_data_length <= next_length;
			end
		end
	end

	// All ones means nothing is sent, and so does a zero length.
	assign global_data_active = ext_on && (global_data_start != `GD_ADDR_RESET)
		&& (global_data_length != 16'h0000);

	assign map_index = in_field(addr, `OFS_IN_MAP, {3'h0, `MAP_BYTES}) ?
		(addr - `OFS_IN_MAP) : (addr - `OFS_OUT_MAP);

	// Read data decode; any byte outside the image, or unused bits, read zero.
	always @* begin
		next_rdata = 8'h00;
		if (addr == `OFS_VARIANT) begin
			next_rdata = VARIANT_CODE;
		end else if (addr == `OFS_REVISION) begin
			next_rdata = REVISION_CODE;
		end else if (addr == `OFS_DEV_COUNT) begin
			next_rdata = device_count;
		end else if (addr == `OFS_OWN_DEV) begin
			next_rdata = {3'h0, own_number};
		end else if (addr == `OFS_LINK_RATE) begin
			next_rdata = {5'h00, link_rate};
		end else if (in_field(addr, `OFS_IN_MAP, {3'h0, `MAP_BYTES})) begin
			next_rdata = input_reference_map[map_index[3:0]*8 +: 8];
		end else if (in_field(addr, `OFS_OUT_MAP, {3'h0, `MAP_BYTES})) begin
			next_rdata = output_reference_map[map_index[3:0]*8 +: 8];
		end else if (ext_on && in_field(addr, `OFS_INHIBIT, `INHIBIT_BYTES)) begin
			next_rdata = output_inhibit[flag_index[1:0]*8 +: 8];
		end else if (ext_on && (addr == `OFS_GD_ADDR)) begin
			next_rdata = global_data_start[7:0];
		end else if (ext_on && (addr == `OFS_GD_ADDR + 8'h01)) begin
			next_rdata = global_data_start[15:8];
		end else if (ext_on && (addr == `OFS_GD_LEN)) begin
			next_rdata = global_data_length[7:0];
		end else if (ext_on && (addr == `OFS_GD_LEN + 8'h01)) begin
			next_rdata = global_data_length[15:8];
		end
	end

	// Read data stand only in the cycle after the strobe and are zero otherwise.
	always @(posedge clk_sys) begin
		if (srst) begin
			rdata <= 8'h00;
		end else if (rd) begin
			rdata <= next_rdata;
		end else begin
			rdata <= 8'h00;
		end
	end

endmodule // bus_controller_config_image

// ===== bus_controller_config_image_test.sv
// Self-checking bench for the configuration image.
// Assumes the host model drives the byte port; controller inputs come from here.
`timescale 1ns/1ps
module bus_controller_config_image_test;
	reg clk_sys = 1'b0;
	reg srst = 1'b1;
	reg [7:0] active_device_count = 8'h07;
	reg [4:0] own_device_number = 5'h11;
	reg [2:0] link_rate_code = 3'h3;
	reg alloc_clear = 1'b0, alloc_update = 1'b0, alloc_is_output = 1'b0;
	reg alloc_is_register = 1'b0, alloc_value = 1'b0, inhibit_switch = 1'b0;
	reg [6:0] alloc_group = 7'h00;
	reg [31:0] device_present = 32'hffffffff;
	wire [7:0] addr, wdata, rdata;
	wire wr, rd, global_data_active;
	wire [31:0] output_inhibit, output_send_allowed;
	wire [15:0] global_data_start, global_data_length;
	integer fails = 0, num_checks = 0, cycles = 0;
	reg [7:0] got;
	always #4 clk_sys = ~clk_sys;
	host_model host (.*);
	bus_controller_config_image dut (.*);
	task check(input [31:0] seen, input [31:0] want);
		begin
			num_checks = num_checks + 1;
			if (seen !== want) begin
				fails = fails + 1;
				$display("MISMATCH at %0t seen %h expected %h", $time, seen, want);
			end
		end
	endtask
	task chk_rd(input [7:0] a, input [7:0] want);
		begin
			host.rd_byte(a, got);
			check({24'h0, got}, {24'h0, want});
		end
	endtask
	task alloc(input o, input r, input [6:0] g);
		begin
			@(posedge clk_sys);
			{alloc_update, alloc_is_output, alloc_is_register, alloc_value} <= {1'b1, o, r, 1'b1};
			alloc_group <= g;
			@(posedge clk_sys);
			alloc_update <= 1'b0;
		end
	endtask
	task do_reset(input sw);
		begin
			@(posedge clk_sys);
			srst <= 1'b1;
			inhibit_switch <= sw;
			repeat (10) @(posedge clk_sys);
			srst <= 1'b0;
			@(posedge clk_sys);
		end
	endtask
	task test_done;
		begin
			if (fails == 0 && num_checks > 0)
				$display("SIMULATION PASSED");
			else
				$display("SIMULATION FAILED");
			$finish;
		end
	endtask
	always @(posedge clk_sys) begin
		cycles = cycles + 1;
		if (cycles == 3000) begin
			fails = fails + 1;
			test_done;
		end
	end
	initial begin
		do_reset(1'b0);
		host.wr_byte(8'h00, 8'h33);
		chk_rd(8'h00, 8'h5a);
		chk_rd(8'h02, 8'h07);
		host.wr_byte(8'h03, 8'h09);
		chk_rd(8'h03, 8'h11);
		@(posedge clk_sys) own_device_number <= 5'h00;
		chk_rd(8'h03, 8'h11);
		chk_rd(8'h04, 8'h03);
		chk_rd(8'h29, 8'h00);
		chk_rd(8'h2b, 8'hff);
		chk_rd(8'h2d, 8'h00);
		chk_rd(8'h2e, 8'h00);
		alloc(1'b0, 1'b0, 7'd0);
		alloc(1'b1, 1'b0, 7'd9);
		alloc(1'b0, 1'b1, 7'd1);
		host.wr_byte(8'h06, 8'hff);
		chk_rd(8'h06, 8'h01);
		chk_rd(8'h17, 8'h02);
		@(posedge clk_sys) alloc_clear <= 1'b1;
		@(posedge clk_sys) alloc_clear <= 1'b0;
		chk_rd(8'h17, 8'h00);
		host.wr_byte(8'h26, 8'h01);
		host.wr_byte(8'h29, 8'h80);
		#1 check(output_send_allowed, 32'h7ffffffe);
		check(output_inhibit, 32'h80000001);
		host.wr_byte(8'h2c, 8'h40);
		host.wr_byte(8'h2c, 8'h90);
		chk_rd(8'h2c, 8'h80);
		host.wr_byte(8'h2d, 8'h01);
		#1 check({16'h0, global_data_length}, 32'h80);
		host.wr_byte(8'h2b, 8'h01);
		#1 check({31'h0, global_data_active}, 32'h1);
		check({16'h0, global_data_start}, 32'h01ff);
		do_reset(1'b1);
		chk_rd(8'h26, 8'hff);
		chk_rd(8'h2b, 8'hff);
		chk_rd(8'h2c, 8'h00);
		test_done;
	end
endmodule // bus_controller_config_image_test

// ===== cfg_image_checker.sv
// Assertions on the configuration image register port.
// Assumes it is bound into the image and sees only the image's ports.
`timescale 1ns/1ps
module cfg_image_checker #(
	parameter [7:0] VARIANT_CODE = 8'h5a
) (
	input wire clk_sys,
	input wire srst,
	input wire [7:0] addr,
	input wire [7:0] wdata,
	input wire wr,
	input wire rd,
	input wire [7:0] rdata,
	input wire [31:0] output_inhibit,
	input wire [15:0] global_data_length,
	input wire [15:0] global_data_start
);
	// Marks that reset stood at the previous edge, so the reset values have landed.
	reg rst_held = 1'b0;
	always @(posedge clk_sys) begin
		rst_held <= srst;
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);
	property p_variant; $past(rd) && $past(addr) == 8'h00 |-> rdata == VARIANT_CODE; endproperty
	a_variant: assert property (p_variant) else $error("variant byte wrong");
	property p_own;
		$past(rd) && $past(addr) == 8'h03 |-> rdata[7:5] == 3'h0 && rdata[4:0] != 5'h00;
	endproperty
	a_own: assert property (p_own) else $error("own number byte wrong");
	property p_len; global_data_length <= 16'h0080; endproperty
	a_len: assert property (p_len) else $error("length above limit");
	// Checked while reset is held, so this one carries no disable.
	property p_rst;
		disable iff (1'b0) srst && rst_held |->
			global_data_start == 16'hffff && global_data_length == 16'h0000;
	endproperty
	a_rst: assert property (p_rst) else $error("global data reset value wrong");
	property p_powerup; $fell(srst) |=> output_inhibit == 32'h0 || output_inhibit == 32'hffffffff;
	endproperty
	a_powerup: assert property (p_powerup) else $error("flags not uniform at start");
	property p_wr_len;
		$past(wr) && $past(addr) == 8'h2c && $past(wdata) <= 8'h80 &&
			$past(global_data_length[15:8]) == 8'h00 |-> global_data_length[7:0] == $past(wdata);
	endproperty
	a_wr_len: assert property (p_wr_len) else $error("length low byte not stored");
	property p_flags_wr; $past(wr) && $past(addr) == 8'h26 |-> output_inhibit[7:0] == $past(wdata);
	endproperty
	a_flags_wr: assert property (p_flags_wr) else $error("flag byte not stored");
endmodule // cfg_image_checker

bind bus_controller_config_image cfg_image_checker #(.VARIANT_CODE(VARIANT_CODE)) chk (.*);

// ===== cfg_image_consts.vh
// Byte offsets, field layouts, reset values and limits of the configuration image.
// Assumes byte-wide access where the image offset is the port address.
`ifndef CFG_IMAGE_CONSTS_VH
`define CFG_IMAGE_CONSTS_VH

`define ADDR_W 8
`define OFS_VARIANT 8'h00
`define OFS_REVISION 8'h01
`define OFS_DEV_COUNT 8'h02
`define OFS_OWN_DEV 8'h03
`define OFS_LINK_RATE 8'h04
`define OFS_SPARE 8'h05
`define OFS_IN_MAP 8'h06
`define OFS_OUT_MAP 8'h16
`define OFS_INHIBIT 8'h26
`define OFS_GD_ADDR 8'h2a
`define OFS_GD_LEN 8'h2c
`define OFS_LAST 8'h2d
`define MAP_BYTES 5'h10
`define MAP_GROUPS 128
`define MAP_USED_GROUPS 125
`define OWN_DEV_W 5
`define OWN_DEV_MIN 5'h01
`define LINK_RATE_W 3
`define INHIBIT_BYTES 8'h04
`define DEVICES 32
`define GD_ADDR_RESET 16'hffff
`define GD_LEN_RESET 16'h0000
`define GD_LEN_MAX 16'h0080

`endif

// ===== host_model.sv
// Host processor model that reads and writes the image over the byte port.
// Assumes one shared clock and no request before reset has been released.
`timescale 1ns/1ps
module host_model (
	input wire clk_sys,
	input wire [7:0] rdata,
	output reg [7:0] addr = 8'h00,
	output reg [7:0] wdata = 8'h00,
	output reg wr = 1'b0,
	output reg rd = 1'b0
);
	// Idle lines are inverted so a stale address never looks like a live one.
	task wr_byte(input [7:0] a, input [7:0] d);
		begin
			@(posedge clk_sys);
			addr <= a;
			wdata <= d;
			wr <= 1'b1;
			@(posedge clk_sys);
			wr <= 1'b0;
			addr <= ~a;
			wdata <= ~d;
		end
	endtask
	task rd_byte(input [7:0] a, output [7:0] d);
		begin
			@(posedge clk_sys);
			addr <= a;
			rd <= 1'b1;
			@(posedge clk_sys);
			rd <= 1'b0;
			addr <= ~a;
			#1 d = rdata;
		end
	endtask
endmodule // host_model

// ===== ref_group_map.v
// Allocation bitmap of reference groups, one bit per group of eight references.
// Assumes updates come from controller logic on the same clock.
`timescale 1ns/1ps
`include "cfg_image_consts.vh"

module ref_group_map #(
	parameter GROUPS = `MAP_GROUPS,
	parameter USED_GROUPS = `MAP_USED_GROUPS,
	parameter GROUP_W = 7
) (
	input wire clk_sys,
	input wire srst,
	input wire clear_all,
	input wire update_en,
	input wire [GROUP_W-1:0] group,
	input wire value,
	output reg [GROUPS-1:0] map
);

	integer i;

	always @(posedge clk_sys) begin
		if (srst) begin
			map <= {GROUPS{1'b0}};
		end else if (clear_all) begin
			map <= {GROUPS{1'b0}};
		end else begin
			for (i = 0; i < GROUPS; i = i + 1) begin
				// Groups past the last reference never exist, so their bits stay zero.
				if (update_en && (group == i) && (i < USED_GROUPS)) begin
					map[i] <= value;
				end
			end
		end
	end

endmodule // ref_group_map
